// [src/cltp_interval_timer.sv]
// down-counter for sleep and settling intervals
// assumes load is a one-cycle pulse and count is at least one
`timescale 1ns/10ps
module cltp_interval_timer #(
   parameter int WIDTH = 42
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic load,
   input wire logic [WIDTH-1:0] count,
   output logic expired
);

   logic [WIDTH-1:0] cnt_r;
   logic run_r;

   generate
      if (WIDTH < 2) begin : g_bad_width
         $error("cltp_interval_timer: WIDTH below 2");
      end
   endgenerate

   // expired rises exactly count cycles after the load pulse
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
         run_r <= 1'b0;
      end else if (load) begin
         cnt_r <= count;
         run_r <= 1'b1;
      end else if (run_r) begin
         cnt_r <= cnt_r - WIDTH'(1);
         if (cnt_r == WIDTH'(1)) begin
            run_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         expired <= 1'b0;
      end else if (load) begin
         expired <= 1'b0;
      end else if (run_r && cnt_r == WIDTH'(1)) begin
         expired <= 1'b1;
      end
   end

endmodule

// [src/cltp_pkg.sv]
// package for the calibration trigger and low-power sequencing block
// assumes one device clock; register indices are word indices on the bus
package cltp_pkg;

   // register indices, byte address is four times the index
   localparam logic [7:0] IDX_PIN_SETUP = 8'h6b;
   localparam logic [7:0] IDX_SOFT_TRIG = 8'h6c;
   localparam logic [7:0] IDX_LOW_POWER = 8'h6e;
   localparam logic [7:0] IDX_READBACK = 8'h70;
   localparam logic [7:0] IDX_BG_CTRL = 8'hf0;
   localparam logic [7:0] IDX_STATE = 8'hf1;
   localparam logic [7:0] IDX_INT_STATUS = 8'hf2;
   localparam logic [7:0] IDX_INT_MASK = 8'hf3;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 9;

   // reset values
   localparam logic [7:0] RST_PIN_SETUP = 8'h00;
   localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
   localparam logic [7:0] RST_LOW_POWER = 8'h88;
   localparam logic [7:0] RST_READBACK = 8'h00;
   localparam logic [7:0] RST_BG_CTRL = 8'h00;
   localparam logic [3:0] RST_INT = 4'h0;

   // field positions
   localparam int POS_TRIG_SRC = 0;
   localparam int POS_STAT_SEL_LO = 1;
   localparam int POS_SOFT_TRIG = 0;
   localparam int POS_LOW_POWER_ENABLE = 0;
   localparam int POS_WAKE_MODE = 1;
   localparam int POS_WAKE_LO = 3;
   localparam int POS_SLEEP_LO = 5;
   localparam int POS_BG_EN = 0;
   localparam int POS_READBACK_EN = 0;

   // status pin source codes
   localparam logic [1:0] STAT_FOREGROUND_DONE_FLAG = 2'h0;
   localparam logic [1:0] STAT_RESERVED = 2'h1;
   localparam logic [1:0] STAT_ALARM = 2'h2;
   localparam logic [1:0] STAT_LOW = 2'h3;

   // interrupt event bits
   localparam int EV_FOREGROUND_DONE_FLAG = 0;
   localparam int EV_ALARM = 1;
   localparam int EV_WAKE = 2;
   localparam int EV_CORE_CAL = 3;
   localparam int EV_NUM = 4;

   // interval = (2^k + 1) * 2^SCALE device-clock periods
   localparam int INTERVAL_SCALE = 8;
   localparam logic [47:0] SLEEP_K_DEF = {6'h21, 6'h1e, 6'h1b, 6'h18, 6'h15, 6'h12, 6'h0f, 6'h03};
   localparam logic [23:0] WAKE_K_DEF = {6'h18, 6'h15, 6'h12, 6'h03};

   // ahb transfer type
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

   typedef enum logic [1:0] {
      LP_OFF = 2'b00,
      LP_CAL = 2'b01,
      LP_SLEEP = 2'b10,
      LP_WAKE = 2'b11
   } cltp_lp_state_t;

   typedef struct packed {
      logic [2:0] sleep_code;
      logic [1:0] wake_code;
      logic rsvd;
      logic wake_mode;
      logic low_power_enable;
   } cltp_lp_cfg_t;

   typedef struct packed {
      logic write;
      logic [7:0] index;
      logic mapped;
   } cltp_ahb_req_t;

endpackage

// [src/cltp_top.sv]
// calibration trigger selection, status pin routing and low-power
// background calibration sequencing, with an ahb-lite register slave
// assumes the calibration engine runs on CLK; the trigger pin is asynchronous
//
// Behaviour
// - Status select code 0 shows foreground done, 1 is reserved, 2 shows alarm, 3 holds the pin low.
// - With trigger source 0 the software trigger bit is used and the trigger pin is ignored.
// - With trigger source 1 the trigger pin is used and the software trigger bit is ignored.
// - Sleep code k picks (2^k+1)*256 clock periods, k being 3,15,18,21,24,27,30,33 for codes 0 to 7.
// - The sleep interval only applies with low power on and trigger-wake mode off.
// - After wake the block waits (2^k+1)*256 periods, k being 3,18,21,24 for wake codes 0 to 3.
// - Wake mode 0 sleeps for the timed interval, wake mode 1 sleeps until the trigger is low.
// - The low-power enable bit acts only while background calibration is on.
// - The low-power register is at 0x06E and resets to 0x88.
// - The software trigger register is at 0x06C and resets to 0x01.
// - The readback enable register is at 0x070 and resets to 0x00.
// - The foreground done flag marks a finished foreground run and feeds status code 0.
// - A background calibration enable bit, reset to 0, gates low-power operation.
//
// Local design decision: register access over AHB-Lite.
`timescale 1ns/10ps
module cltp_top #(
   parameter int CNT_WIDTH = 42,
   parameter logic [47:0] SLEEP_K = cltp_pkg::SLEEP_K_DEF,
   parameter logic [23:0] WAKE_K = cltp_pkg::WAKE_K_DEF
) (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic HW_TRIGGER_IN,
   input wire logic FOREGROUND_DONE_FLAG_IN,
   input wire logic ALARM_IN,
   input wire logic CORE_CAL_DONE,
   output logic CAL_TRIGGER,
   output logic STATUS_PIN,
   output logic CORE_SLEEP,
   output logic CORE_CAL_REQ,
   output logic BG_CAL_EN,
   output logic READBACK_EN,
   output logic IRQ
);

   localparam int SCALE = cltp_pkg::INTERVAL_SCALE;

   function automatic logic [CNT_WIDTH-1:0] interval(input logic [5:0] k);
      logic [CNT_WIDTH-1:0] v;
      v = (CNT_WIDTH'(1) << k) + CNT_WIDTH'(1);
      interval = v << SCALE;
   endfunction

   // the longest interval must fit the counter
   generate
      if (CNT_WIDTH < 42) begin : g_bad_cnt
         $error("cltp_top: CNT_WIDTH too small for the longest interval");
      end
   endgenerate

   logic rst_meta_r;
   logic rst_n;
   logic trig_meta_r;
   logic trig_sync_r;

   logic [7:0] pin_setup_r;
   logic [7:0] soft_trig_r;
   cltp_pkg::cltp_lp_cfg_t lp_cfg_r;
   logic [7:0] readback_r;
   logic [7:0] bg_ctrl_r;
   logic [cltp_pkg::EV_NUM-1:0] int_status_r;
   logic [cltp_pkg::EV_NUM-1:0] int_mask_r;

   cltp_pkg::cltp_ahb_req_t req_r;
   logic wr_pend_r;
   logic rd_pend_r;
   logic addr_ok;
   logic [7:0] wdata;
   logic [7:0] rd_mux;
   logic wr_hit;

   logic eff_trig;
   logic lp_active;
   logic foreground_done_flag_d_r;
   logic alarm_d_r;
   logic [cltp_pkg::EV_NUM-1:0] events;

   cltp_pkg::cltp_lp_state_t state_r;
   cltp_pkg::cltp_lp_state_t state_nxt;
   logic tmr_load;
   logic [CNT_WIDTH-1:0] tmr_count;
   logic tmr_expired;

   // reset release through two flops
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rst_meta_r <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n <= rst_meta_r;
      end
   end

   // trigger pin is asynchronous
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         trig_meta_r <= 1'b0;
         trig_sync_r <= 1'b0;
      end else begin
         trig_meta_r <= HW_TRIGGER_IN;
         trig_sync_r <= trig_meta_r;
      end
   end

   // bus address phase
   assign addr_ok = (HADDR[31:cltp_pkg::IDX_MSB+1] == '0) && (HADDR[1:0] == 2'h0);
   assign wdata = HWDATA[7:0];
   assign wr_hit = wr_pend_r && req_r.mapped;

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         req_r <= '0;
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         HREADYOUT <= 1'b1;
      end else begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         HREADYOUT <= 1'b1;
         if (HSEL && HREADY && HTRANS == cltp_pkg::HTRANS_NONSEQ) begin
            req_r.write <= HWRITE;
            req_r.index <= HADDR[cltp_pkg::IDX_MSB:cltp_pkg::IDX_LSB];
            req_r.mapped <= addr_ok;
            wr_pend_r <= HWRITE;
            rd_pend_r <= !HWRITE;
            // reads take one wait state so the data come from a flop
            HREADYOUT <= HWRITE;
         end
      end
   end

   always_comb begin
      rd_mux = 8'h00;
      if (req_r.mapped) begin
         unique case (req_r.index)
            cltp_pkg::IDX_PIN_SETUP: rd_mux = pin_setup_r;
            cltp_pkg::IDX_SOFT_TRIG: rd_mux = soft_trig_r;
            cltp_pkg::IDX_LOW_POWER: rd_mux = lp_cfg_r;
            cltp_pkg::IDX_READBACK: rd_mux = readback_r;
            cltp_pkg::IDX_BG_CTRL: rd_mux = bg_ctrl_r;
            cltp_pkg::IDX_STATE: rd_mux = {2'h0, state_r, eff_trig, lp_active, ALARM_IN, FOREGROUND_DONE_FLAG_IN};
            cltp_pkg::IDX_INT_STATUS: rd_mux = {4'h0, int_status_r};
            cltp_pkg::IDX_INT_MASK: rd_mux = {4'h0, int_mask_r};
            default: rd_mux = 8'h00;
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         HRDATA <= 32'h0000_0000;
      end else if (rd_pend_r) begin
         HRDATA <= {24'h00_0000, rd_mux};
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         HRESP <= 1'b0;
      end else begin
         HRESP <= 1'b0;
      end
   end

   // configuration registers, written in the data phase
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         pin_setup_r <= cltp_pkg::RST_PIN_SETUP;
         soft_trig_r <= cltp_pkg::RST_SOFT_TRIG;
         lp_cfg_r <= cltp_pkg::RST_LOW_POWER;
         readback_r <= cltp_pkg::RST_READBACK;
         bg_ctrl_r <= cltp_pkg::RST_BG_CTRL;
         int_mask_r <= cltp_pkg::RST_INT;
      end else if (wr_hit) begin
         unique case (req_r.index)
            cltp_pkg::IDX_PIN_SETUP: pin_setup_r <= wdata;
            cltp_pkg::IDX_SOFT_TRIG: soft_trig_r <= wdata;
            cltp_pkg::IDX_LOW_POWER: lp_cfg_r <= wdata;
            cltp_pkg::IDX_READBACK: readback_r <= wdata;
            cltp_pkg::IDX_BG_CTRL: bg_ctrl_r <= wdata;
            cltp_pkg::IDX_INT_MASK: int_mask_r <= wdata[cltp_pkg::EV_NUM-1:0];
            default: ;
         endcase
      end
   end

   // trigger source selection
   always_comb begin
      if (pin_setup_r[cltp_pkg::POS_TRIG_SRC]) begin
         eff_trig = trig_sync_r;
      end else begin
         eff_trig = soft_trig_r[cltp_pkg::POS_SOFT_TRIG];
      end
   end

   // low power only counts while background calibration is on
   assign lp_active = lp_cfg_r.low_power_enable && bg_ctrl_r[cltp_pkg::POS_BG_EN];

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         CAL_TRIGGER <= 1'b0;
         BG_CAL_EN <= 1'b0;
         READBACK_EN <= 1'b0;
      end else begin
         CAL_TRIGGER <= eff_trig;
         BG_CAL_EN <= bg_ctrl_r[cltp_pkg::POS_BG_EN];
         READBACK_EN <= readback_r[cltp_pkg::POS_READBACK_EN];
      end
   end

   // status pin routing; reserved code drives low
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         STATUS_PIN <= 1'b0;
      end else begin
         unique case (pin_setup_r[cltp_pkg::POS_STAT_SEL_LO +: 2])
            cltp_pkg::STAT_FOREGROUND_DONE_FLAG: STATUS_PIN <= FOREGROUND_DONE_FLAG_IN;
            cltp_pkg::STAT_RESERVED: STATUS_PIN <= 1'b0;
            cltp_pkg::STAT_ALARM: STATUS_PIN <= ALARM_IN;
            cltp_pkg::STAT_LOW: STATUS_PIN <= 1'b0;
         endcase
      end
   end

   // low-power sequencer
   always_comb begin
      state_nxt = state_r;
      tmr_load = 1'b0;
      tmr_count = interval(WAKE_K[6*lp_cfg_r.wake_code +: 6]);
      if (!lp_active) begin
         state_nxt = cltp_pkg::LP_OFF;
      end else begin
         unique case (state_r)
            cltp_pkg::LP_OFF: state_nxt = cltp_pkg::LP_CAL;
            cltp_pkg::LP_CAL: begin
               if (CORE_CAL_DONE) begin
                  state_nxt = cltp_pkg::LP_SLEEP;
                  tmr_load = 1'b1;
                  tmr_count = interval(SLEEP_K[6*lp_cfg_r.sleep_code +: 6]);
               end
            end
            cltp_pkg::LP_SLEEP: begin
               // wake mode ignores the timer and waits for a low trigger
               if (lp_cfg_r.wake_mode ? !eff_trig : tmr_expired) begin
                  state_nxt = cltp_pkg::LP_WAKE;
                  tmr_load = 1'b1;
               end
            end
            cltp_pkg::LP_WAKE: begin
               if (tmr_expired) begin
                  state_nxt = cltp_pkg::LP_CAL;
               end
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= cltp_pkg::LP_OFF;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         CORE_SLEEP <= 1'b0;
         CORE_CAL_REQ <= 1'b0;
      end else begin
         CORE_SLEEP <= (state_nxt == cltp_pkg::LP_SLEEP);
         CORE_CAL_REQ <= (state_nxt == cltp_pkg::LP_CAL);
      end
   end

   cltp_interval_timer #(
      .WIDTH(CNT_WIDTH)
   ) u_timer (
      .clk(CLK),
      .rst_n(rst_n),
      .load(tmr_load),
      .count(tmr_count),
      .expired(tmr_expired)
   );

   // events: rising flags, wake-up, finished core calibration
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         foreground_done_flag_d_r <= 1'b0;
         alarm_d_r <= 1'b0;
      end else begin
         foreground_done_flag_d_r <= FOREGROUND_DONE_FLAG_IN;
         alarm_d_r <= ALARM_IN;
      end
   end

   always_comb begin
      events = '0;
      events[cltp_pkg::EV_FOREGROUND_DONE_FLAG] = FOREGROUND_DONE_FLAG_IN && !foreground_done_flag_d_r;
      events[cltp_pkg::EV_ALARM] = ALARM_IN && !alarm_d_r;
      events[cltp_pkg::EV_WAKE] = (state_r == cltp_pkg::LP_SLEEP) && (state_nxt == cltp_pkg::LP_WAKE);
      events[cltp_pkg::EV_CORE_CAL] = (state_r == cltp_pkg::LP_CAL) && (state_nxt == cltp_pkg::LP_SLEEP);
   end

   // write one to clear; a new event in the same cycle wins
   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         int_status_r <= cltp_pkg::RST_INT;
      end else if (wr_hit && req_r.index == cltp_pkg::IDX_INT_STATUS) begin
         int_status_r <= (int_status_r & ~wdata[cltp_pkg::EV_NUM-1:0]) | events;
      end else begin
         int_status_r <= int_status_r | events;
      end
   end

   always_ff @(posedge CLK or negedge rst_n) begin
      if (!rst_n) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(int_status_r & int_mask_r);
      end
   end

endmodule

// [verification/cltp_asserts.sv]
// port-level checker for cltp_top
// assumes one clock domain; attached to every cltp_top by the bind below
`timescale 1ns/10ps
module cltp_asserts (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic HSEL,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic HREADY,
   input wire logic [31:0] HRDATA,
   input wire logic HREADYOUT,
   input wire logic HRESP,
   input wire logic FOREGROUND_DONE_FLAG_IN,
   input wire logic ALARM_IN,
   input wire logic CORE_CAL_DONE,
   input wire logic STATUS_PIN,
   input wire logic CORE_SLEEP,
   input wire logic CORE_CAL_REQ,
   input wire logic BG_CAL_EN
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RSTN);
   logic take;
   assign take = HSEL && HREADY && HTRANS == cltp_pkg::HTRANS_NONSEQ;
   okay_resp_a: assert property (!HRESP) else $error("response not okay");
   read_wait_a: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
      else $error("read wait state wrong");
   write_nowait_a: assert property (take && HWRITE |=> HREADYOUT)
      else $error("write stalled");
   data_upper_a: assert property (HRDATA[31:8] == 24'h0)
      else $error("read data upper bits set");
   status_src_a: assert property (STATUS_PIN |-> $past(FOREGROUND_DONE_FLAG_IN) || $past(ALARM_IN))
      else $error("status pin high without source");
   cal_to_sleep_a: assert property (CORE_CAL_REQ && CORE_CAL_DONE |=> !CORE_CAL_REQ)
      else $error("calibration request held after done");
   wake_gap_a: assert property ($fell(CORE_SLEEP) |=> !CORE_CAL_REQ [*8])
      else $error("calibration before settling");
   sleep_excl_a: assert property (!(CORE_SLEEP && CORE_CAL_REQ))
      else $error("sleep and calibrate together");
   bg_gate_a: assert property (!BG_CAL_EN [*2] |-> !CORE_SLEEP && !CORE_CAL_REQ)
      else $error("low power active without background enable");
endmodule

bind cltp_top cltp_asserts chk_u (.CLK, .RSTN, .HSEL, .HTRANS, .HWRITE, .HREADY, .HRDATA, .HREADYOUT,
   .HRESP, .FOREGROUND_DONE_FLAG_IN, .ALARM_IN, .CORE_CAL_DONE, .STATUS_PIN, .CORE_SLEEP, .CORE_CAL_REQ, .BG_CAL_EN);

// [verification/cltp_engine_model.sv]
// calibration engine stand-in: one done pulse every DELAY+2 cycles of request
// assumes the request is a registered level on clk
`timescale 1ns/10ps
module cltp_engine_model #(
   parameter int DELAY = 10
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic cal_req,
   output logic cal_done
);
   int cnt;
   // pulse only while requested, again every DELAY+2 cycles while the request stays high
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 0;
         cal_done <= 1'b0;
      end else begin
         cal_done <= cal_req && !cal_done && cnt == DELAY;
         cnt <= (cal_req && !cal_done && cnt < DELAY) ? cnt + 1 : 0;
      end
   end
endmodule

// [verification/tb.sv]
// self-checking bench for cltp_top through its ahb-lite port
// assumes the engine stand-in answers core calibration requests
`timescale 1ns/10ps
module tb;
   logic clk, rstn, hsel, hwrite, hw_trig, foreground_done_flag, alarm;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic hreadyout, hresp, cal_done, hardware_trigger_input, stat_pin, sleep, cal_req, bg_en, rb_en, irq;
   int error_cnt = 0;
   int comparisons = 0;
   int n;
   // short k values keep intervals to a few thousand cycles
   cltp_top #(.SLEEP_K({6'h02, 6'h01, 6'h01, 6'h03, 6'h01, 6'h01, 6'h01, 6'h01}),
      .WAKE_K({6'h02, 6'h01, 6'h01, 6'h01})) dut_u (
      .CLK(clk), .RSTN(rstn), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
      .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
      .HRESP(hresp), .HW_TRIGGER_IN(hw_trig), .FOREGROUND_DONE_FLAG_IN(foreground_done_flag), .ALARM_IN(alarm),
      .CORE_CAL_DONE(cal_done), .CAL_TRIGGER(hardware_trigger_input), .STATUS_PIN(stat_pin), .CORE_SLEEP(sleep),
      .CORE_CAL_REQ(cal_req), .BG_CAL_EN(bg_en), .READBACK_EN(rb_en), .IRQ(irq));
   cltp_engine_model eng_u (.clk(clk), .rst_n(rstn), .cal_req(cal_req), .cal_done(cal_done));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [31:0] len(input int k);
      return ((32'h1 << k) + 32'h1) << 8;
   endfunction

   task automatic close_out();
      $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   // no cycle limit here: only the watchdog may end a stuck transfer
   task automatic wait_ready();
      @(posedge clk);
      while (hreadyout !== 1'b1) begin
         @(posedge clk);
      end
   endtask

   // entered just after a rising edge; read data taken at the data-phase edge
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      hsel <= 1'b1;
      htrans <= cltp_pkg::HTRANS_NONSEQ;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'b00};
      wait_ready();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready();
      rd = hrdata;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(1'b1, idx, {24'h0, d});
   endtask

   task automatic chk_reg(input logic [7:0] idx, input logic [31:0] exp);
      xfer(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask

   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask

   // counts edges at which the chosen output still shows lvl
   task automatic span(input bit use_req, input logic lvl);
      n = 0;
      while ((use_req ? cal_req : sleep) === lvl && n < 5000) begin
         n++;
         @(posedge clk);
      end
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      error_cnt++;
      close_out();
   end

   initial begin
      rstn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h0;
      hwdata = 32'h0;
      hw_trig = 1'b0;
      foreground_done_flag = 1'b0;
      alarm = 1'b0;
      cyc(4);
      rstn <= 1'b1;
      cyc(3);
      chk_reg(8'h6b, 32'h00);
      chk_reg(8'h6c, 32'h01);
      chk_reg(8'h6e, 32'h88);
      chk_reg(8'h70, 32'h00);
      chk_reg(8'hf0, 32'h00);
      chk1(hardware_trigger_input, 1'b1);
      wr(8'h10, 8'hff);
      chk_reg(8'h10, 32'h00);
      wr(8'h70, 8'hff);
      chk_reg(8'h70, 32'hff);
      chk1(rb_en, 1'b1);
      $display("test reset_regs done");
      hw_trig <= 1'b1;
      wr(8'h6c, 8'h00);
      cyc(6);
      chk1(hardware_trigger_input, 1'b0);
      wr(8'h6b, 8'h01);
      cyc(6);
      chk1(hardware_trigger_input, 1'b1);
      wr(8'h6c, 8'h01);
      hw_trig <= 1'b0;
      cyc(6);
      chk1(hardware_trigger_input, 1'b0);
      wr(8'h6b, 8'h00);
      cyc(6);
      chk1(hardware_trigger_input, 1'b1);
      $display("test trigger_source done");
      for (int c = 0; c < 4; c++) begin
         wr(8'h6b, 8'(c << 1));
         for (int s = 0; s < 2; s++) begin
            foreground_done_flag <= (s == 0);
            alarm <= (s == 1);
            cyc(3);
            chk1(stat_pin, c == 0 ? s == 0 : c == 2 ? s == 1 : 1'b0);
         end
      end
      foreground_done_flag <= 1'b0;
      alarm <= 1'b0;
      $display("test status_pin done");
      chk_reg(8'hf2, 32'h03);
      chk1(irq, 1'b0);
      wr(8'hf3, 8'h01);
      cyc(2);
      chk1(irq, 1'b1);
      wr(8'hf2, 8'h01);
      cyc(2);
      chk1(irq, 1'b0);
      chk_reg(8'hf2, 32'h02);
      wr(8'hf2, 8'h02);
      wr(8'hf3, 8'h0c);
      $display("test interrupts done");
      wr(8'h6e, 8'h89);
      cyc(20);
      chk1(cal_req, 1'b0);
      wr(8'hf0, 8'h01);
      for (int t = 0; t < 2; t++) begin
         // sleep codes stay at 4 or above and wake codes above 0
         wr(8'h6e, t ? 8'hf9 : 8'h89);
         span(1'b0, 1'b0);
         span(1'b0, 1'b1);
         chk(32'(n), len(t ? 2 : 3) + 32'h1);
         span(1'b1, 1'b0);
         chk(32'(n), len(t ? 2 : 1) + 32'h1);
      end
      chk_reg(8'hf2, 32'h0c);
      chk1(irq, 1'b1);
      wr(8'hf2, 8'h0c);
      $display("test timed_sleep done");
      wr(8'h6e, 8'h8b);
      span(1'b0, 1'b0);
      cyc(3000);
      chk1(sleep, 1'b1);
      // state view: sleeping, trigger high, low power active
      chk_reg(8'hf1, 32'h2c);
      wr(8'h6c, 8'h00);
      span(1'b0, 1'b1);
      chk1(n < 8, 1'b1);
      wr(8'h6c, 8'h01);
      wr(8'hf0, 8'h00);
      cyc(3);
      chk1(sleep | cal_req, 1'b0);
      chk1(bg_en, 1'b0);
      $display("test trigger_wake done");
      close_out();
   end
endmodule
